// *** inc/brake_pkg.sv ***
/*
  Constants, types and the register map of the holding-brake sequencer.
  Assumes a single 125 MHz clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package brake_pkg;
  // Clock rate and the millisecond base of every sequence delay
  localparam int CLK_HZ        = 125_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  // Field widths
  localparam int DLY_W  = 16;
  localparam int FREQ_W = 16;
  localparam int DUTY_W = 8;
  localparam int OFS_W  = 8;

  // Register byte offsets
  localparam logic [OFS_W-1:0] OFS_SUBMODE = 8'h00;
  localparam logic [OFS_W-1:0] OFS_DOUT    = 8'h04;
  localparam logic [OFS_W-1:0] OFS_DRIVE   = 8'h08;
  localparam logic [OFS_W-1:0] OFS_DLY1    = 8'h0c;
  localparam logic [OFS_W-1:0] OFS_FREQ    = 8'h1c;
  localparam logic [OFS_W-1:0] OFS_DUTY    = 8'h20;
  localparam logic [OFS_W-1:0] OFS_STATUS  = 8'h24;
  localparam logic [OFS_W-1:0] DLY_STRIDE  = 8'h04;
  localparam int               NUM_DLY     = 4;

  // Field positions
  localparam int AUTO_BIT   = 2;  // motor_drive_submode_select
  localparam int BRAKE_BIT  = 0;  // digital_output_bits
  localparam int REQ_BIT    = 0;  // drive control: operation enable request
  localparam int ST_LSB     = 0;  // status: state code, 7 bits
  localparam int BRAKE_STAT = 8;
  localparam int CUR_STAT   = 9;
  localparam int OPEN_STAT  = 10;
  localparam int HALT_STAT  = 11;

  // Limits and reset values
  localparam logic [FREQ_W-1:0] FREQ_MAX    = 16'd2000;
  localparam logic [FREQ_W-1:0] FREQ_MIN    = 16'd1;
  localparam logic [DUTY_W-1:0] DUTY_MIN    = 8'd2;
  localparam logic [DUTY_W-1:0] DUTY_MAX    = 8'd100;
  localparam logic [7:0]        SUBMODE_RST = 8'h04;
  localparam logic [31:0]       DOUT_RST    = 32'h0000_0000;
  localparam logic [DLY_W-1:0]  DLY_RST     = 16'h0000;
  localparam logic [FREQ_W-1:0] FREQ_RST    = 16'd1000;
  localparam logic [DUTY_W-1:0] DUTY_RST    = 8'd100;
  localparam logic [6:0]        PCT_LAST    = 7'd99;

  // Brake sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_OFF     = 7'h01,
    ST_POWER   = 7'h02,
    ST_RELEASE = 7'h04,
    ST_ENABLED = 7'h08,
    ST_HALT    = 7'h10,
    ST_HOLD    = 7'h20,
    ST_ENGAGE  = 7'h40
  } seq_state_e;

  // Brake PWM settings
  typedef struct packed {
    logic [FREQ_W-1:0] freq_hz;
    logic [DUTY_W-1:0] duty_pct;
  } pwm_cfg_s;

  // Captured AHB address phase
  typedef struct packed {
    logic             write;
    logic             mapped;
    logic [OFS_W-1:0] ofs;
  } ahb_req_s;
endpackage : brake_pkg
`default_nettype wire

// *** hdl/brake_pwm.sv ***
/*
  Brake PWM generator: 1 percent duty slots, frequency set in hertz.
  Assumes cfg is already held within its legal range by the register file.
*/
`default_nettype none
module brake_pwm
  import brake_pkg::*;
#(
  parameter int CLOCK_HZ = CLK_HZ
)(
  input  wire logic     hclk,
  input  wire logic     hresetn,
  input  wire logic     energise,
  input  wire pwm_cfg_s cfg,
  output logic          level
);
  localparam int             ACC_W = $clog2(CLOCK_HZ) + 2;
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLOCK_HZ);

  logic [ACC_W-1:0] acc;
  logic [6:0]       slot;
  wire  [ACC_W-1:0] step     = ACC_W'(32'(cfg.freq_hz) * 32'(DUTY_MAX));
  wire  [ACC_W-1:0] acc_sum  = acc + step;
  wire              slot_adv = (acc_sum >= WRAP);
  wire              full_on  = (cfg.duty_pct >= DUTY_MAX);
  wire              slot_hi  = ({1'b0, slot} < cfg.duty_pct);

  // Phase accumulator gives freq*100 slot steps per second without a divider
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      acc  <= '0;
      slot <= '0;
    end
    else if (!energise)
    begin
      acc  <= '0;  // Restart so each energise begins with a high slot
      slot <= '0;
    end
    else
    begin
      acc  <= slot_adv ? acc_sum - WRAP : acc_sum;
      slot <= slot_adv ? ((slot == PCT_LAST) ? 7'd0 : slot + 7'd1) : slot;
    end

  // Output level; a full duty setting holds the output steadily on
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      level <= 1'b0;
    else
      level <= energise & (full_on | slot_hi);
endmodule : brake_pwm
`default_nettype wire

// *** hdl/brake_sequencer.sv ***
/*
  Holding-brake sequencer with brake PWM and an AHB-Lite register file.
  Assumes the power state machine asks for operation enabled through the
  drive control register, and the motion logic on hclk reports standstill.

*/
`default_nettype none
module brake_sequencer
  import brake_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        standstill,
  output logic             brake_out,
  output logic             motor_current_on,
  output logic             operation_enabled,
  output logic             motor_halt
);
  localparam int PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  function automatic logic [FREQ_W-1:0] clamp_freq(input logic [31:0] v);
    clamp_freq = (v > 32'(FREQ_MAX)) ? FREQ_MAX : (v < 32'(FREQ_MIN)) ? FREQ_MIN : v[FREQ_W-1:0];
  endfunction : clamp_freq

  function automatic logic [DUTY_W-1:0] clamp_duty(input logic [31:0] v);
    clamp_duty = (v > 32'(DUTY_MAX)) ? DUTY_MAX : (v < 32'(DUTY_MIN)) ? DUTY_MIN : v[DUTY_W-1:0];
  endfunction : clamp_duty

  ahb_req_s          req_q;
  logic              wr_pend;
  logic              rd_pend;
  logic [7:0]        submode_select;
  logic [31:0]       digital_output_bits;
  logic              op_request;
  logic [DLY_W-1:0]  delay [NUM_DLY];
  pwm_cfg_s          pwm_cfg;
  seq_state_e        state;
  seq_state_e        next_state;
  logic [PRE_W-1:0]  pre_cnt;
  logic [DLY_W-1:0]  ms_cnt;
  logic              pwm_level;

  // Address phase decode; only whole-word transfers reach the registers
  wire accept    = hsel & htrans[1] & hready;
  wire word_xfer = (hsize == 3'b010);
  wire in_map    = (haddr[31:OFS_W] == '0) & (haddr[1:0] == 2'b00) & word_xfer;

  // Data phase write strobes
  wire wr_en   = wr_pend & req_q.mapped;
  wire wr_sub  = wr_en & (req_q.ofs == OFS_SUBMODE);
  wire wr_dout = wr_en & (req_q.ofs == OFS_DOUT);
  wire wr_drv  = wr_en & (req_q.ofs == OFS_DRIVE);
  wire wr_freq = wr_en & (req_q.ofs == OFS_FREQ);
  wire wr_duty = wr_en & (req_q.ofs == OFS_DUTY);

  wire auto_mode = submode_select[AUTO_BIT];

  // Sequencer outputs decoded from the state
  wire seq_current = (state != ST_OFF);
  wire seq_release = (state == ST_RELEASE) | (state == ST_ENABLED) | (state == ST_HALT) | (state == ST_HOLD);
  wire seq_halt    = (state == ST_HALT) | (state == ST_HOLD) | (state == ST_ENGAGE);

  // Delay that applies to the current waiting state
  wire [DLY_W-1:0] cur_delay = (state == ST_POWER)   ? delay[2] :
                               (state == ST_RELEASE) ? delay[3] :
                               (state == ST_HOLD)    ? delay[0] :
                               (state == ST_ENGAGE)  ? delay[1] : DLY_RST;
  wire dly_done = (ms_cnt >= cur_delay);
  wire ms_tick  = (pre_cnt == PRE_LAST);

  // Read data selection; reserved bits read as zero
  wire [31:0] status_word = {20'h0, motor_halt, operation_enabled, motor_current_on, brake_out, 1'b0, 7'(state)};
  wire [OFS_W-1:0] dly_rel = req_q.ofs - OFS_DLY1;
  wire is_dly = (req_q.ofs >= OFS_DLY1) & (req_q.ofs < OFS_FREQ);
  wire [31:0] rdata = !req_q.mapped                 ? 32'h0 :
                      (req_q.ofs == OFS_SUBMODE)    ? {24'h0, submode_select} :
                      (req_q.ofs == OFS_DOUT)       ? digital_output_bits :
                      (req_q.ofs == OFS_DRIVE)      ? {31'h0, op_request} :
                      is_dly                        ? {16'h0, delay[dly_rel[3:2]]} :
                      (req_q.ofs == OFS_FREQ)       ? {16'h0, pwm_cfg.freq_hz} :
                      (req_q.ofs == OFS_DUTY)       ? {24'h0, pwm_cfg.duty_pct} :
                      (req_q.ofs == OFS_STATUS)     ? status_word : 32'h0;

  // Bus handshake: writes take no wait state, reads one, so a read right
  // after a write always sees the value just written
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      req_q     <= '0;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end
    else
    begin
      if (accept)
        req_q <= '{write: hwrite, mapped: in_map, ofs: haddr[OFS_W-1:0]};
      wr_pend   <= accept & hwrite;
      rd_pend   <= accept & !hwrite;
      hreadyout <= !(accept & !hwrite);
      hresp     <= 1'b0;  // Always OKAY
      if (rd_pend)
        hrdata <= rdata;
    end

  // Mode, drive request and PWM settings
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      submode_select <= SUBMODE_RST;
      op_request     <= 1'b0;
      pwm_cfg        <= '{freq_hz: FREQ_RST, duty_pct: DUTY_RST};
    end
    else
    begin
      if (wr_sub)
        submode_select <= hwdata[7:0];
      if (wr_drv)
        op_request <= hwdata[REQ_BIT];
      if (wr_freq)
        pwm_cfg.freq_hz <= clamp_freq(hwdata);
      if (wr_duty)
        pwm_cfg.duty_pct <= clamp_duty(hwdata);
    end

  // Output bits; in automatic mode the sequencer owns bit 0 and wins over software
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      digital_output_bits <= DOUT_RST;
    else
    begin
      if (wr_dout)
        digital_output_bits <= hwdata;
      if (auto_mode)
        digital_output_bits[BRAKE_BIT] <= seq_release;
    end

  // Delay settings, one register per delay
  for (genvar i = 0; i < NUM_DLY; i++)
  begin : g_dly
    wire wr_this = wr_en & (req_q.ofs == OFS_DLY1 + OFS_W'(i) * DLY_STRIDE);
    always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
        delay[i] <= DLY_RST;
      else if (wr_this)
        delay[i] <= hwdata[DLY_W-1:0];
  end

  // Next state of the brake sequence
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:     if (op_request) next_state = ST_POWER;
      ST_POWER:   if (!op_request) next_state = ST_HALT; else if (dly_done) next_state = ST_RELEASE;
      ST_RELEASE: if (!op_request) next_state = ST_HALT; else if (dly_done) next_state = ST_ENABLED;
      ST_ENABLED: if (!op_request) next_state = ST_HALT;
      ST_HALT:    if (standstill) next_state = ST_HOLD;
      ST_HOLD:    if (dly_done) next_state = ST_ENGAGE;
      ST_ENGAGE:  if (dly_done) next_state = ST_OFF;
      default:    next_state = ST_OFF;
    endcase
  end

  // State register and millisecond timer; the timer restarts on every state change
  // reset engaged and idle
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state   <= ST_OFF;
      pre_cnt <= '0;
      ms_cnt  <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
      begin
        pre_cnt <= '0;
        ms_cnt  <= '0;
      end
      else
      begin
        pre_cnt <= ms_tick ? '0 : pre_cnt + PRE_W'(1);
        if (ms_tick && ms_cnt != '1)
          ms_cnt <= ms_cnt + DLY_W'(1);  // Saturates, never wraps to zero
      end
    end

  // Brake is energised from output bit 0 in either mode
  // bit 0 steers brake
  brake_pwm #(
    .CLOCK_HZ (CLK_HZ)
  ) u_pwm (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .energise (digital_output_bits[BRAKE_BIT]),
    .cfg      (pwm_cfg),
    .level    (pwm_level)
  );

  // Drive outputs, all registered
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      brake_out         <= 1'b0;
      motor_current_on  <= 1'b0;
      operation_enabled <= 1'b0;
      motor_halt        <= 1'b0;
    end
    else
    begin
      brake_out         <= pwm_level;
      motor_current_on  <= seq_current;
      operation_enabled <= (state == ST_ENABLED);
      motor_halt        <= seq_halt;
    end
endmodule : brake_sequencer
`default_nettype wire

// *** testbench/brake_sequencer_properties.sv ***
/*
  Port checker of the brake sequencer, bound into every instance.
  Assumes one clock and hready tied to hreadyout.
*/
`default_nettype none
module brake_sequencer_properties
  import brake_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
)(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       brake_out,
  input wire logic       motor_current_on,
  input wire logic       operation_enabled,
  input wire logic       motor_halt
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transfer taken by the slave
  wire take = hsel && htrans[1] && hready;
  // Sequence outputs, checked against each other and at reset release
  AST_ENABLE_POWERED: assert property (operation_enabled |-> motor_current_on && !motor_halt)
    else $error("enable without current");
  AST_ENABLE_LATE: assert property ($rose(operation_enabled) |-> $past(motor_current_on, 2))
    else $error("enable too early");
  AST_POWER_CLEAN: assert property ($rose(motor_current_on) |-> !motor_halt ##1 motor_current_on)
    else $error("bad current start");
  AST_LEAVE_HALTS: assert property ($fell(operation_enabled) |-> motor_halt)
    else $error("leave without halt");
  AST_HALT_POWERED: assert property (motor_halt |-> motor_current_on)
    else $error("halt without current");
  AST_OFF_AFTER_ENGAGE: assert property ($fell(motor_current_on) |-> $past(motor_halt))
    else $error("current dropped early");
  AST_RESET_QUIET: assert property ($rose(hresetn) |-> !brake_out && !motor_current_on && hreadyout)
    else $error("outputs after reset");
  // Bus answer: one wait per read, none per write
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout && !hresp)
    else $error("read wait");
  AST_WRITE_NO_WAIT: assert property (take && hwrite |=> hreadyout && !hresp)
    else $error("write wait");
  cover property ($rose(operation_enabled));
  cover property ($fell(motor_current_on));
  cover property (take && !hwrite);
endmodule : brake_sequencer_properties

bind brake_sequencer brake_sequencer_properties #(.MS_CYCLES(MS_CYCLES)) i_brake_sequencer_properties (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .brake_out,
  .motor_current_on, .operation_enabled, .motor_halt);
`default_nettype wire

// *** testbench/brake_model.sv ***
/*
  Holding brake and motion partner of the brake sequencer.
  Assumes the brake pin and drive outputs on the same clock.
*/
`default_nettype none
module brake_model #(
  parameter int HOLD = 8
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        brake_out,
  input  wire logic        operation_enabled,
  input  wire logic [15:0] stop_cycles,
  output logic             standstill,
  output logic             released
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold_left;
  int coast;
  // Armature stays in for HOLD cycles after the coil drops; motor coasts
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_left  <= 0;
      coast      <= 0;
      standstill <= 1'b1;
    end
    else
    begin
      hold_left  <= brake_out ? HOLD : (hold_left > 0 ? hold_left - 1 : 0);
      coast      <= operation_enabled ? 0 : coast + 1;
      standstill <= !operation_enabled && coast >= int'(stop_cycles);
    end
  end
  assign released = hold_left != 0;
endmodule : brake_model
`default_nettype wire

// *** testbench/brake_sequencer_test.sv ***
/*
  Self-checking bench: registers over AHB-Lite, both sequences, brake PWM.
  Assumes brake_pkg, brake_model and the bound checker.
*/
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module brake_sequencer_test
  import brake_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS = 10;  // Short millisecond keeps the run brief
  localparam int PERIOD = CLK_HZ / 2000;
  localparam logic [7:0] RST_OFS [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  localparam logic [31:0] RST_VAL [10] = '{32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3e8, 32'h64, 32'h1};
  localparam logic [7:0] CL_OFS [6] = '{8'h1c, 8'h1c, 8'h1c, 8'h20, 8'h20, 8'h20};
  localparam logic [31:0] CL_IN [6] = '{32'hbb8, 32'h0, 32'h7d0, 32'h1, 32'h65, 32'h64};
  localparam logic [31:0] CL_EXP [6] = '{32'h7d0, 32'h1, 32'h7d0, 32'h2, 32'h64, 32'h64};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] stop_cycles = 16'h1e;
  wire         hready, hresp, brake_out, motor_current_on, operation_enabled, motor_halt, standstill, released;
  wire  [31:0] hrdata;
  wire  [4:0]  now_v = {standstill, brake_out, motor_current_on, operation_enabled, motor_halt};
  logic [4:0]  prev = 5'h0;
  logic [31:0] rd;
  int          cyc, checked, miscompares, hi;
  int          t_rise [5];
  int          t_fall [5];

  brake_sequencer #(.MS_CYCLES(MS)) i_brake_sequencer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .standstill, .brake_out,
    .motor_current_on, .operation_enabled, .motor_halt);
  brake_model i_brake_model (.hclk, .hresetn, .brake_out, .operation_enabled, .stop_cycles, .standstill,
    .released);

  always #4 hclk = ~hclk;

  // Edge times of the watched outputs, so tasks can measure delays afterwards
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    prev <= now_v;
    for (int i = 0; i < 5; i++)
    begin
      if (now_v[i] && !prev[i]) t_rise[i] <= cyc;
      if (!now_v[i] && prev[i]) t_fall[i] <= cyc;
    end
  end

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, {24'h0, a}, 32'h0);
    `CHK("register", e, rd)
  endtask : rchk

  // Bounded wait; a hang is left to the watchdog
  task automatic wait_bit(input int i, input logic v);
    for (int n = 0; n < 70000 && now_v[i] !== v; n++) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask : wait_bit

  task automatic seq_on(input int d1, input int d2, input int d3, input int d4);
    int d [4];
    d = '{d1, d2, d3, d4};
    for (int k = 0; k < 4; k++) bus(1'b1, 32'h0c + 4 * k, d[k]);
    bus(1'b1, 32'h08, 32'h1);
    wait_bit(1, 1'b1);
    `CHK("brake delay", d3 * MS + 3, t_rise[3] - t_rise[2])
    `CHK("enable delay", (d3 + d4) * MS + 2, t_rise[1] - t_rise[2])
  endtask : seq_on

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (90000) @(posedge hclk);
    miscompares++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(RST_OFS[i], RST_VAL[i]);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, {24'h0, CL_OFS[i]}, CL_IN[i]);
      rchk(CL_OFS[i], CL_EXP[i]);
    end
    // Unmapped place neither answers nor aliases
    bus(1'b1, 32'h100, 32'h0);
    bus(1'b0, 32'h100, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    rchk(OFS_SUBMODE, 32'h4);
    bus(1'b1, 32'h04, 32'h1);
    repeat (8) @(posedge hclk);
    `CHK("auto idle brake", 1'b0, brake_out)
    bus(1'b1, 32'h00, 32'h0);
    bus(1'b1, 32'h04, 32'h1);
    repeat (5) @(posedge hclk);
    hi = 0;
    repeat (200) @(posedge hclk) hi += int'(brake_out === 1'b1);
    `CHK("manual brake", 200, hi)
    bus(1'b1, 32'h04, 32'h0);
    bus(1'b1, 32'h00, 32'h4);
    // Slow stop with timed delays
    seq_on(1, 1, 2, 1);
    rchk(OFS_STATUS, 32'h708);
    rchk(OFS_DOUT, 32'h1);
    bus(1'b1, 32'h08, 32'h0);
    wait_bit(2, 1'b0);
    `CHK("engage wait", 1'b1, t_fall[3] - t_rise[4] >= MS)
    `CHK("current wait", MS - 1, t_fall[2] - t_fall[3])
    `CHK("brake held", 1'b0, released)
    rchk(OFS_STATUS, 32'h1);
    // Prompt stop, zero delays, duty at its floor
    stop_cycles <= 16'h0;
    bus(1'b1, 32'h20, 32'h2);
    seq_on(0, 0, 0, 0);
    hi = 0;
    repeat (PERIOD) @(posedge hclk) hi += int'(brake_out === 1'b1);
    `CHK("pwm high", PERIOD * 2 / 100, hi)
    bus(1'b1, 32'h08, 32'h0);
    wait_bit(2, 1'b0);
    `CHK("brake after stop", 1'b0, brake_out)
    end_sim();
  end
endmodule : brake_sequencer_test
`default_nettype wire
